// >>> verilog/dgro_pkg.sv
// Purpose: Shared constants and types for the transmit gain ramp and output guard
// Assumes: One 25 MHz sample clock; byte-wide register port
// Notes:
// Function
// [RULE_01] Add 16-bit offset to every Q sample
// [RULE_02] Scale I sample by 6-bit gain, unity 0x20
// [RULE_03] Scale Q sample by own 6-bit gain
// [RULE_04] Ramp up by step every four cycles
// [RULE_05] Ramp down by step every four cycles
// [RULE_06] Software keeps steps below I gain
// [RULE_07] Manual off bit needs IQ gain enabled
// [RULE_08] Status bit reads one while output off; code holds it at its last value while IQ gain is disabled
// [RULE_09] Transmit pin ramps output when enabled
// [RULE_10] Sleep while pin low if enabled
// [RULE_11] Power down while pin low if enabled
// [RULE_12] Master enable gates all protection controls
// [RULE_13] FIFO warning shuts output when enabled
// [RULE_14] Over-threshold power shuts output when enabled
// [RULE_15] FIFO error bit shuts output on warning
// [RULE_16] Settled gain holds channel gain setting
// [RULE_17] Shutdown ramps if stepping, else immediate
package dgro_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_Q_OFFSET_LOW   = 8'h3d;
    localparam logic [7:0] ADDR_Q_OFFSET_HIGH  = 8'h3e;
    localparam logic [7:0] ADDR_I_GAIN         = 8'h3f;
    localparam logic [7:0] ADDR_Q_GAIN         = 8'h40;
    localparam logic [7:0] ADDR_RISE_STEP      = 8'h41;
    localparam logic [7:0] ADDR_FALL_STEP      = 8'h42;
    localparam logic [7:0] ADDR_PIN_ACTIONS    = 8'h43;
    localparam logic [7:0] ADDR_PROTECT        = 8'h44;

    // Reset values
    localparam logic [7:0] RST_Q_OFFSET_LOW    = 8'h00;
    localparam logic [7:0] RST_Q_OFFSET_HIGH   = 8'h00;
    localparam logic [5:0] RST_I_GAIN          = 6'h20;
    localparam logic [5:0] RST_Q_GAIN          = 6'h20;
    localparam logic [5:0] RST_RISE_STEP       = 6'h01;
    localparam logic [5:0] RST_FALL_STEP       = 6'h01;
    localparam logic       RST_MANUAL_OFF      = 1'b0;
    localparam logic       RST_OUTPUT_OFF      = 1'b1;
    localparam logic [2:0] RST_PIN_ACTIONS     = 3'h7;
    localparam logic [7:0] RST_PROTECT         = 8'h8d;

    // Field positions
    localparam int BIT_MANUAL_OFF      = 7;
    localparam int BIT_OUTPUT_STATUS   = 6;
    localparam int BIT_PIN_RAMP_EN     = 2;
    localparam int BIT_PIN_SLEEP_EN    = 1;
    localparam int BIT_PIN_PDOWN_EN    = 0;
    localparam int BIT_PROTECT_MASTER  = 7;
    localparam int BIT_WARN_CUTOFF     = 3;
    localparam int BIT_POWER_CUTOFF    = 2;
    localparam int BIT_ERROR_CUTOFF    = 0;
    localparam int GAIN_FRAC_BITS      = 5;

    // Bits of the protection register that exist
    localparam logic [7:0] PROTECT_MASK        = 8'h8d;

    // Last count of the step counter, four cycles between ramp steps
    localparam logic [1:0] STEP_PERIOD_LAST    = 2'h3;

    typedef enum logic [1:0] {
        DGRO_OFF       = 2'b00,
        DGRO_RAMP_UP   = 2'b01,
        DGRO_ON        = 2'b10,
        DGRO_RAMP_DOWN = 2'b11
    } dgro_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dgro_reg_req_type;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } dgro_iq_type;

endpackage

// >>> verilog/dgro_scale.sv
// Purpose: One channel gain multiply, offset add and saturation
// Assumes: Gain in units of 2^-5, signed twos complement samples
// Notes: Purely combinational; caller registers the result
`timescale 1ns/10ps
module dgro_scale (
    // Sample and controls
    input  wire logic [15:0] sample_i,
    input  wire logic [6:0]  gain_i,
    input  wire logic [15:0] offset_i,
    // Result
    output logic      [15:0] result_o
);
    logic signed [23:0] product;
    logic signed [18:0] scaled;
    logic signed [19:0] summed;

    always_comb begin
        product = $signed(sample_i) * $signed({1'b0, gain_i});
        scaled  = product[23:dgro_pkg::GAIN_FRAC_BITS];
        summed  = {scaled[18], scaled} + {{4{offset_i[15]}}, offset_i};
        if (summed > 20'sd32767) begin
            result_o = 16'h7fff;
        end else if (summed < -20'sd32768) begin
            result_o = 16'h8000;
        end else begin
            result_o = summed[15:0];
        end
    end
endmodule

// >>> verilog/dgro_top.sv
// Purpose: I/Q gain, Q offset, transmit gain ramp and output guard
// Assumes: All inputs synchronous to ref_clk_i; registers on a byte port
// Notes: ce_i low freezes every flop, including the read data
`timescale 1ns/10ps
module dgro_top (
    // Clock, reset, enable
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ce_i,
    // Register port
    input  wire dgro_pkg::dgro_reg_req_type reg_req_i,
    output logic      [7:0]                reg_rdata_o,
    // Baseband pin and system controls
    input  wire logic                      transmit_enable_pin_i,
    input  wire logic                      iq_gain_enable_i,
    // Guard event inputs
    input  wire logic                      fifo_warning_i,
    input  wire logic                      over_threshold_i,
    // Sample path
    input  wire dgro_pkg::dgro_iq_type     sample_i,
    output dgro_pkg::dgro_iq_type          sample_o,
    // Status and mode outputs
    output logic                           sleep_o,
    output logic                           powerdown_o,
    output logic                           output_off_o,
    output logic                           ramp_busy_o,
    output logic      [6:0]                gain_applied_o
);
    // Register storage
    logic [7:0]  q_offset_low_r;
    logic [7:0]  q_offset_high_byte_r;
    logic [5:0]  i_channel_gain_field_r;
    logic [5:0]  q_channel_gain_field_r;
    logic [5:0]  rise_step_r;
    logic [5:0]  fall_step_r;
    logic        manual_off_r;
    logic        output_off_r;
    logic        pin_ramp_enable_r;
    logic        pin_sleep_enable_r;
    logic        pin_powerdown_enable_r;
    logic [7:0]  protect_r;
    logic [7:0]  rdata_r;

    // Ramp control
    dgro_pkg::dgro_state_type state_r;
    dgro_pkg::dgro_state_type state_nxt;
    logic [6:0]  ramp_gain_r;
    logic [6:0]  ramp_gain_nxt;
    logic [1:0]  step_cnt_r;
    logic        step_due;

    // Output stage
    logic [15:0] i_scaled;
    logic [15:0] q_scaled;
    logic [6:0]  i_gain_use;
    logic [6:0]  q_gain_use;
    dgro_pkg::dgro_iq_type sample_r;
    logic        sleep_r;
    logic        powerdown_r;

    // Decoded controls
    logic [6:0]  target_gain;
    logic [6:0]  rise_amount;
    logic [6:0]  fall_amount;
    logic [7:0]  rise_sum;
    logic        master_en;
    logic        guard_trip;
    logic        manual_trip;
    logic        pin_allows;
    logic        want_on;
    logic        wr_en;
    logic        rd_en;

    assign wr_en = ce_i & reg_req_i.wr;
    assign rd_en = ce_i & reg_req_i.rd;

    // Software writes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q_offset_low_r         <= dgro_pkg::RST_Q_OFFSET_LOW;
            q_offset_high_byte_r   <= dgro_pkg::RST_Q_OFFSET_HIGH;
            i_channel_gain_field_r <= dgro_pkg::RST_I_GAIN;
            q_channel_gain_field_r <= dgro_pkg::RST_Q_GAIN;
            rise_step_r            <= dgro_pkg::RST_RISE_STEP;
            fall_step_r            <= dgro_pkg::RST_FALL_STEP;
            manual_off_r           <= dgro_pkg::RST_MANUAL_OFF;
            pin_ramp_enable_r      <= dgro_pkg::RST_PIN_ACTIONS[dgro_pkg::BIT_PIN_RAMP_EN];
            pin_sleep_enable_r     <= dgro_pkg::RST_PIN_ACTIONS[dgro_pkg::BIT_PIN_SLEEP_EN];
            pin_powerdown_enable_r <= dgro_pkg::RST_PIN_ACTIONS[dgro_pkg::BIT_PIN_PDOWN_EN];
            protect_r              <= dgro_pkg::RST_PROTECT;
        end else if (wr_en) begin
            unique case (reg_req_i.addr)
                dgro_pkg::ADDR_Q_OFFSET_LOW: begin
                    q_offset_low_r <= reg_req_i.wdata;
                end
                dgro_pkg::ADDR_Q_OFFSET_HIGH: begin
                    q_offset_high_byte_r <= reg_req_i.wdata;
                end
                dgro_pkg::ADDR_I_GAIN: begin
                    i_channel_gain_field_r <= reg_req_i.wdata[5:0];
                end
                dgro_pkg::ADDR_Q_GAIN: begin
                    q_channel_gain_field_r <= reg_req_i.wdata[5:0];
                end
                dgro_pkg::ADDR_RISE_STEP: begin
                    rise_step_r <= reg_req_i.wdata[5:0];
                end
                dgro_pkg::ADDR_FALL_STEP: begin
                    // Status bit is read-only, write ignored
                    fall_step_r  <= reg_req_i.wdata[5:0];
                    manual_off_r <= reg_req_i.wdata[dgro_pkg::BIT_MANUAL_OFF];
                end
                dgro_pkg::ADDR_PIN_ACTIONS: begin
                    pin_ramp_enable_r      <= reg_req_i.wdata[dgro_pkg::BIT_PIN_RAMP_EN];
                    pin_sleep_enable_r     <= reg_req_i.wdata[dgro_pkg::BIT_PIN_SLEEP_EN];
                    pin_powerdown_enable_r <= reg_req_i.wdata[dgro_pkg::BIT_PIN_PDOWN_EN];
                end
                dgro_pkg::ADDR_PROTECT: begin
                    protect_r <= reg_req_i.wdata & dgro_pkg::PROTECT_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data, registered; unmapped and reserved bits read zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (rd_en) begin
            unique case (reg_req_i.addr)
                dgro_pkg::ADDR_Q_OFFSET_LOW: begin
                    rdata_r <= q_offset_low_r;
                end
                dgro_pkg::ADDR_Q_OFFSET_HIGH: begin
                    rdata_r <= q_offset_high_byte_r;
                end
                dgro_pkg::ADDR_I_GAIN: begin
                    rdata_r <= {2'b00, i_channel_gain_field_r};
                end
                dgro_pkg::ADDR_Q_GAIN: begin
                    rdata_r <= {2'b00, q_channel_gain_field_r};
                end
                dgro_pkg::ADDR_RISE_STEP: begin
                    rdata_r <= {2'b00, rise_step_r};
                end
                dgro_pkg::ADDR_FALL_STEP: begin
                    rdata_r <= {manual_off_r, output_off_r, fall_step_r}; // [RULE_08]
                end
                dgro_pkg::ADDR_PIN_ACTIONS: begin
                    rdata_r <= {5'h00, pin_ramp_enable_r, pin_sleep_enable_r, pin_powerdown_enable_r};
                end
                dgro_pkg::ADDR_PROTECT: begin
                    rdata_r <= protect_r;
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    // Guard and request decode
    always_comb begin
        master_en   = protect_r[dgro_pkg::BIT_PROTECT_MASTER]; // [RULE_12]
        guard_trip  = master_en & (
                      (protect_r[dgro_pkg::BIT_WARN_CUTOFF]  & fifo_warning_i)     // [RULE_13]
                    | (protect_r[dgro_pkg::BIT_POWER_CUTOFF] & over_threshold_i)   // [RULE_14]
                    | (protect_r[dgro_pkg::BIT_ERROR_CUTOFF] & fifo_warning_i));   // [RULE_15]
        manual_trip = manual_off_r & iq_gain_enable_i; // [RULE_07]
        pin_allows  = ~pin_ramp_enable_r | transmit_enable_pin_i; // [RULE_09]
        want_on     = pin_allows & ~manual_trip & ~guard_trip;
    end

    // Step sizes carry one fewer fraction bit than the gain
    always_comb begin
        target_gain = {1'b0, i_channel_gain_field_r};
        rise_amount = {rise_step_r, 1'b0};
        fall_amount = {fall_step_r, 1'b0};
        rise_sum    = {1'b0, ramp_gain_r} + {1'b0, rise_amount};
    end

    // Step pacing, one step each four cycles
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            step_cnt_r <= 2'h0;
        end else if (ce_i) begin
            if (state_nxt != state_r) begin
                step_cnt_r <= 2'h0;
            end else begin
                step_cnt_r <= step_cnt_r + 2'h1;
            end
        end
    end

    assign step_due = (step_cnt_r == dgro_pkg::STEP_PERIOD_LAST); // [RULE_04] [RULE_05]

    // Ramp state machine
    always_comb begin
        state_nxt     = state_r;
        ramp_gain_nxt = ramp_gain_r;
        unique case (state_r)
            dgro_pkg::DGRO_OFF: begin
                ramp_gain_nxt = 7'h00;
                if (want_on) begin
                    if (pin_ramp_enable_r) begin
                        state_nxt = dgro_pkg::DGRO_RAMP_UP; // [RULE_09]
                    end else begin
                        state_nxt     = dgro_pkg::DGRO_ON;
                        ramp_gain_nxt = target_gain;
                    end
                end
            end
            dgro_pkg::DGRO_RAMP_UP: begin
                if (!want_on) begin
                    if (pin_ramp_enable_r) begin
                        state_nxt = dgro_pkg::DGRO_RAMP_DOWN; // [RULE_17]
                    end else begin
                        state_nxt     = dgro_pkg::DGRO_OFF;
                        ramp_gain_nxt = 7'h00;
                    end
                end else if (ramp_gain_r >= target_gain) begin
                    state_nxt     = dgro_pkg::DGRO_ON;
                    ramp_gain_nxt = target_gain;
                end else if (step_due) begin
                    // Clamp guards against a step above the gain [RULE_06]
                    if (rise_sum >= {1'b0, target_gain}) begin
                        ramp_gain_nxt = target_gain; // [RULE_04]
                        state_nxt     = dgro_pkg::DGRO_ON;
                    end else begin
                        ramp_gain_nxt = rise_sum[6:0]; // [RULE_04]
                    end
                end
            end
            dgro_pkg::DGRO_ON: begin
                ramp_gain_nxt = target_gain; // [RULE_16]
                if (!want_on) begin
                    if (pin_ramp_enable_r) begin
                        state_nxt = dgro_pkg::DGRO_RAMP_DOWN; // [RULE_17]
                    end else begin
                        state_nxt     = dgro_pkg::DGRO_OFF; // [RULE_17]
                        ramp_gain_nxt = 7'h00;
                    end
                end
            end
            dgro_pkg::DGRO_RAMP_DOWN: begin
                if (!pin_ramp_enable_r) begin
                    state_nxt     = dgro_pkg::DGRO_OFF;
                    ramp_gain_nxt = 7'h00;
                end else if (want_on) begin
                    state_nxt = dgro_pkg::DGRO_RAMP_UP;
                end else if (step_due) begin
                    if (ramp_gain_r <= fall_amount) begin
                        ramp_gain_nxt = 7'h00; // [RULE_05]
                        state_nxt     = dgro_pkg::DGRO_OFF;
                    end else begin
                        ramp_gain_nxt = ramp_gain_r - fall_amount; // [RULE_05]
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r     <= dgro_pkg::DGRO_OFF;
            ramp_gain_r <= 7'h00;
        end else if (ce_i) begin
            state_r     <= state_nxt;
            ramp_gain_r <= ramp_gain_nxt;
        end
    end

    // Status follows output only while IQ gain is enabled
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            output_off_r <= dgro_pkg::RST_OUTPUT_OFF;
        end else if (ce_i && iq_gain_enable_i) begin
            output_off_r <= (state_nxt == dgro_pkg::DGRO_OFF); // [RULE_08]
        end
    end

    // Pin low power modes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sleep_r     <= 1'b0;
            powerdown_r <= 1'b0;
        end else if (ce_i) begin
            sleep_r     <= pin_sleep_enable_r & ~transmit_enable_pin_i;     // [RULE_10]
            powerdown_r <= pin_powerdown_enable_r & ~transmit_enable_pin_i; // [RULE_11]
        end
    end

    // Per-channel gain; during a ramp both channels share the ramp gain
    always_comb begin
        if (state_r == dgro_pkg::DGRO_ON) begin
            i_gain_use = {1'b0, i_channel_gain_field_r}; // [RULE_02] [RULE_16]
            q_gain_use = {1'b0, q_channel_gain_field_r}; // [RULE_03] [RULE_16]
        end else begin
            i_gain_use = ramp_gain_r;
            q_gain_use = ramp_gain_r;
        end
    end

    dgro_scale u_scale_i (
        .sample_i (sample_i.i),
        .gain_i   (i_gain_use),
        .offset_i (16'h0000),
        .result_o (i_scaled)
    );

    dgro_scale u_scale_q (
        .sample_i (sample_i.q),
        .gain_i   (q_gain_use),
        .offset_i ({q_offset_high_byte_r, q_offset_low_r}), // [RULE_01]
        .result_o (q_scaled)
    );

    // Output samples, forced to zero when off
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sample_r <= '0;
        end else if (ce_i) begin
            if (state_r == dgro_pkg::DGRO_OFF) begin
                sample_r <= '0; // [RULE_17]
            end else begin
                sample_r.i <= i_scaled;
                sample_r.q <= q_scaled;
            end
        end
    end

    assign reg_rdata_o    = rdata_r;
    assign sample_o       = sample_r;
    assign sleep_o        = sleep_r;
    assign powerdown_o    = powerdown_r;
    assign output_off_o   = output_off_r;
    assign ramp_busy_o    = state_r[0];
    assign gain_applied_o = ramp_gain_r;

endmodule

// >>> tb/dgro_bb_model.sv
// Purpose: Baseband side driving the transmit enable pin
// Assumes: Bench requests a level
// Notes: Pin launched on the falling edge
`timescale 1ns/10ps
module dgro_bb_model (
    // Clock and request
    input  wire logic clk_i,
    input  wire logic want_tx_i,
    // Pin
    output logic      pin_o
);
    logic want_r;
    always @(posedge clk_i) begin
        want_r <= want_tx_i;
    end
    always @(negedge clk_i) begin
        pin_o <= want_r;
    end
endmodule

// >>> tb/dgro_monitor.sv
// Purpose: Port level checks of the gain ramp and output guard
// Assumes: ce_i stays high while a ramp runs
// Notes: Bound to dgro_top below
`timescale 1ns/10ps
module dgro_monitor (
    // Clock and reset
    input wire logic                       ref_clk_i,
    input wire logic                       rst_n_i,
    // Watched ports
    input wire logic                       ce_i,
    input wire dgro_pkg::dgro_reg_req_type reg_req_i,
    input wire logic [7:0]                 reg_rdata_o,
    input wire logic                       transmit_enable_pin_i,
    input wire logic                       iq_gain_enable_i,
    input wire logic                       sleep_o,
    input wire logic                       powerdown_o,
    input wire logic                       output_off_o,
    input wire logic                       ramp_busy_o,
    input wire logic [6:0]                 gain_applied_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic rd_w = ce_i && reg_req_i.rd;

    AST_GAIN_STEP_GAP: assert property (
        ramp_busy_o && $changed(gain_applied_o) |=> $stable(gain_applied_o)[*3])
        else $error("ramp gain stepped sooner than four cycles");
    AST_RAMP_MOVES: assert property (
        ramp_busy_o |-> ##[1:8] ($changed(gain_applied_o) || !ramp_busy_o))
        else $error("ramp gain stalled");
    AST_GAIN_MAX: assert property (
        gain_applied_o <= 7'h3f)
        else $error("ramp gain above channel gain range");
    AST_SLEEP_PIN: assert property (
        $past(ce_i) && $past(transmit_enable_pin_i) |-> !sleep_o)
        else $error("sleep while pin high");
    AST_PDOWN_PIN: assert property (
        $past(ce_i) && $past(transmit_enable_pin_i) |-> !powerdown_o)
        else $error("power down while pin high");
    AST_RDATA_HOLD: assert property (
        !$past(rd_w) |-> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    AST_PROTECT_RSVD: assert property (
        rd_w && reg_req_i.addr == dgro_pkg::ADDR_PROTECT |=> (reg_rdata_o & ~dgro_pkg::PROTECT_MASK) == 8'h00)
        else $error("unused protection bits read nonzero");
    AST_STATUS_READ: assert property (
        rd_w && reg_req_i.addr == dgro_pkg::ADDR_FALL_STEP |=> reg_rdata_o[6] == $past(output_off_o))
        else $error("status bit read differs from output state");
    AST_STATUS_GATED: assert property (
        !$past(iq_gain_enable_i) |-> $stable(output_off_o))
        else $error("status moved while gain function disabled");
endmodule

bind dgro_top dgro_monitor mon_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .transmit_enable_pin_i(transmit_enable_pin_i),
    .iq_gain_enable_i(iq_gain_enable_i), .sleep_o(sleep_o), .powerdown_o(powerdown_o),
    .output_off_o(output_off_o), .ramp_busy_o(ramp_busy_o), .gain_applied_o(gain_applied_o)
);

// >>> tb/tb.sv
// Purpose: Self-checking bench of the gain ramp and output guard
// Assumes: Inputs change on the falling edge; ce_i held high
// Notes: Every task but tally_and_finish is entered and left on a falling edge
`timescale 1ns/10ps
module tb;
    logic                       ref_clk_i, rst_n_i, want_tx, pin, iq_en, warn, over, sleep, pdown, off, busy;
    dgro_pkg::dgro_reg_req_type req;
    logic [7:0]                 rdata;
    dgro_pkg::dgro_iq_type      smp_in, smp_out;
    logic [6:0]                 gain;
    int                         error_cnt = 0, comparisons = 0, cycle_cnt = 0;

    dgro_top dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_req_i(req), .reg_rdata_o(rdata),
        .transmit_enable_pin_i(pin), .iq_gain_enable_i(iq_en), .fifo_warning_i(warn),
        .over_threshold_i(over), .sample_i(smp_in), .sample_o(smp_out), .sleep_o(sleep),
        .powerdown_o(pdown), .output_off_o(off), .ramp_busy_o(busy), .gain_applied_o(gain)
    );
    dgro_bb_model bb_u (.clk_i(ref_clk_i), .want_tx_i(want_tx), .pin_o(pin));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic tally_and_finish();
        $display("Counts: %0d compared, %0d mismatched", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycle_cnt++;
        if (cycle_cnt == 5000) begin
            error_cnt++;
            $display("FAIL %0t run took too long", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk_i);
        req = '0;
        @(negedge ref_clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk_i);
        req = '0;
        d = rdata;
        @(negedge ref_clk_i);
    endtask

    // Wait for a ramp to start and finish
    task automatic settle(input int n);
        repeat (3) @(negedge ref_clk_i);
        for (int k = 0; k < n && busy === 1'b1; k++) @(negedge ref_clk_i);
        chk(busy, 1'b0, "ramp did not finish");
    endtask

    task automatic wait_move(input logic [6:0] from, output int n);
        n = 0;
        while (gain === from && n < 12) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask

    task automatic t_reset();
        logic [7:0] exp_tab [9] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h01, 8'h41, 8'h07, 8'h8d, 8'h00};
        logic [7:0] d;
        for (int k = 0; k < 9; k++) begin
            rd(8'h3d + k[7:0], d);
            chk(d, exp_tab[k], "reset value");
        end
        chk(sleep, 1'b1, "sleep with pin low");
        chk(pdown, 1'b1, "power down with pin low");
        wr(dgro_pkg::ADDR_PROTECT, 8'hff);
        rd(dgro_pkg::ADDR_PROTECT, d);
        chk(d, 8'h8d, "protection readback");
        wr(dgro_pkg::ADDR_PROTECT, 8'h8d);
        $display("reset values finished");
    endtask

    task automatic t_ramp_up();
        int n;
        iq_en = 1'b1;
        want_tx = 1'b1;
        wait_move(7'h00, n);
        chk(gain, 7'h02, "first rise step");
        wait_move(7'h02, n);
        chk(n, 4, "rise period");
        settle(80);
        chk(gain, 7'h20, "ramp target");
        chk(off, 1'b0, "status on");
        repeat (10) @(negedge ref_clk_i);
        chk(gain, 7'h20, "settled gain");
        wr(dgro_pkg::ADDR_Q_GAIN, 8'h10);
        wr(dgro_pkg::ADDR_Q_OFFSET_HIGH, 8'h01);
        wr(dgro_pkg::ADDR_Q_OFFSET_LOW, 8'h80);
        smp_in = '{i: 16'h1000, q: 16'hf000};
        wr(dgro_pkg::ADDR_I_GAIN, 8'h30);
        chk(smp_out.i, 16'h1800, "I gain 1.5");
        chk(smp_out.q, 16'hf980, "Q gain and offset");
        smp_in.i = 16'hf000;
        @(negedge ref_clk_i);
        chk(smp_out.i, 16'he800, "I negative");
        wr(dgro_pkg::ADDR_I_GAIN, 8'h20);
        $display("ramp up finished");
    endtask

    task automatic t_ramp_down();
        int n;
        logic [7:0] d;
        wr(dgro_pkg::ADDR_FALL_STEP, 8'h02);
        smp_in = '{i: 16'h1000, q: 16'h1000};
        want_tx = 1'b0;
        wait_move(7'h20, n);
        chk(gain, 7'h1c, "first fall step");
        settle(40);
        chk(gain, 7'h00, "fall end");
        chk(off, 1'b1, "status off");
        rd(dgro_pkg::ADDR_FALL_STEP, d);
        chk(smp_out, 32'h0000_0000, "output zero");
        chk(d, 8'h42, "fall register");
        $display("ramp down finished");
    endtask

    task automatic t_manual();
        logic [7:0] d;
        want_tx = 1'b1;
        settle(80);
        iq_en = 1'b0;
        wr(dgro_pkg::ADDR_FALL_STEP, 8'h81);
        repeat (8) @(negedge ref_clk_i);
        chk(gain, 7'h20, "manual off ignored");
        chk(off, 1'b0, "status frozen");
        iq_en = 1'b1;
        settle(80);
        chk(off, 1'b1, "manual off");
        rd(dgro_pkg::ADDR_FALL_STEP, d);
        chk(d, 8'hc1, "manual off readback");
        wr(dgro_pkg::ADDR_FALL_STEP, 8'h01);
        settle(80);
        chk(off, 1'b0, "manual on");
        $display("manual switch finished");
    endtask

    task automatic t_guard();
        logic [7:0] prot [3] = '{8'h88, 8'h84, 8'h81};
        for (int k = 0; k < 3; k++) begin
            wr(dgro_pkg::ADDR_PROTECT, prot[k]);
            over = (k == 1);
            warn = (k != 1);
            settle(80);
            chk(off, 1'b1, "guard trip");
            warn = 1'b0;
            over = 1'b0;
            settle(80);
            chk(off, 1'b0, "guard release");
        end
        wr(dgro_pkg::ADDR_PROTECT, 8'h0d);
        warn = 1'b1;
        over = 1'b1;
        repeat (20) @(negedge ref_clk_i);
        chk({off, busy}, 2'b00, "master cleared");
        warn = 1'b0;
        over = 1'b0;
        $display("guard finished");
    endtask

    task automatic t_immediate();
        wr(dgro_pkg::ADDR_PIN_ACTIONS, 8'h03);
        wr(dgro_pkg::ADDR_PROTECT, 8'h84);
        over = 1'b1;
        @(negedge ref_clk_i);
        chk({off, busy}, 2'b10, "immediate off");
        @(negedge ref_clk_i);
        chk(smp_out, 32'h0000_0000, "immediate zero");
        over = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk(smp_out, 32'h1000_0980, "immediate on");
        $display("immediate guard finished");
    endtask

    task automatic t_pin_modes();
        for (int k = 0; k < 8; k++) begin
            wr(dgro_pkg::ADDR_PIN_ACTIONS, k[7:0]);
            want_tx = 1'b0;
            repeat (4) @(negedge ref_clk_i);
            chk({sleep, pdown}, k[1:0], "pin low modes");
            want_tx = 1'b1;
            repeat (4) @(negedge ref_clk_i);
            chk({sleep, pdown}, 2'b00, "pin high modes");
        end
        $display("pin modes finished");
    endtask

    initial begin
        rst_n_i = 1'b0;
        req = '0;
        want_tx = 1'b0;
        iq_en = 1'b0;
        warn = 1'b0;
        over = 1'b0;
        smp_in = '0;
        repeat (5) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        @(negedge ref_clk_i);
        t_reset();
        t_ramp_up();
        t_ramp_down();
        t_manual();
        t_guard();
        t_immediate();
        t_pin_modes();
        tally_and_finish();
    end
endmodule
